// ===== pfbd_flash_model.sv
// Behavioural parallel NOR flash seen from the controller pins
`timescale 1ns/1ns
`default_nettype none
module pfbd_flash_model (
  input  wire logic        ce_n,    // Chip select
  input  wire logic        oe_n,    // Output enable
  input  wire logic        we_n,    // Write strobe
  input  wire logic        rst_n,   // Hardware reset
  input  wire logic        byte_n,  // Width select
  input  wire logic        wp_n,    // write_protect_accel
  input  wire logic [25:0] addr,    // Word address
  input  wire logic [15:0] dq_o,    // Host data
  input  wire logic [15:0] dq_oe,   // Host enables
  output var  logic [15:0] dq_i     // Resolved data lines
);
  logic [15:0] mem [0:7];  // Small store of written words over uniform 64 Kword sectors
  logic [25:0] tag [0:7];  // Word address held by each slot
  logic [7:0]  used = 8'h00;
  logic [15:0] w, rd, msk;
  // Untouched words read a pattern, so array read is the default
  function automatic logic [15:0] peek(input logic [25:0] a);
    peek = a[15:0] ^ 16'h0f0f;
    for (int i = 0; i < 8; i++)
      if (used[i] && tag[i] == a) peek = mem[i];
  endfunction
  // Lines nobody drives show the inverse, never a stale value
  always @* begin
    w = peek(addr);
    rd = byte_n ? w : {~w[15:8], dq_o[15] ? w[15:8] : w[7:0]};
    msk = (!ce_n && !oe_n && we_n && rst_n) ? (byte_n ? 16'hffff : 16'h00ff) : 16'h0000;
    dq_i = (dq_oe & dq_o) | (~dq_oe & msk & rd) | (~dq_oe & ~msk & ~rd);
  end
  // Word write on strobe rise; top sector guarded while protect is low
  always @(posedge we_n)
    if (!ce_n && rst_n && byte_n && (wp_n || addr[25:16] != 10'h3ff)) begin : store
      int k;
      k = 8;
      // Slots fill in order, so a matching slot always comes before a free one
      for (int i = 7; i >= 0; i--)
        if (!used[i] || tag[i] == addr) k = i;
      if (k < 8) begin
        mem[k] = dq_o;
        tag[k] = addr;
        used[k] = 1'b1;
      end
    end
endmodule
`default_nettype wire

// ===== pfbd_host.v
// Host-side controller driving an asynchronous parallel NOR flash from APB registers
`timescale 1ns/1ns
`default_nettype none
`include "pfbd_regs.vh"
module pfbd_host (
  input  wire        CLK_SYS,      // 25 MHz clock
  input  wire        RSTN,         // Async reset, active low
  input  wire        PSEL,         // APB select
  input  wire        PENABLE,      // APB access phase
  input  wire        PWRITE,       // APB direction
  input  wire [11:0] PADDR,        // APB byte address
  input  wire [31:0] PWDATA,       // APB write data
  output reg  [31:0] PRDATA,       // APB read data
  output reg         PREADY,       // APB ready
  output reg         PSLVERR,      // APB error on unmapped address
  output reg  [25:0] FL_ADDR,      // Flash word address
  input  wire [15:0] FL_DQ_I,      // Flash data in
  output reg  [15:0] FL_DQ_O,      // Flash data out
  output reg  [15:0] FL_DQ_OE,     // Per-line output enable
  output reg         FL_CE_N,      // Chip select, active low
  output reg         FL_OE_N,      // Output enable, active low
  output reg         FL_WE_N,      // Write strobe, active low
  output reg         FL_RESET_N,   // Hardware reset, active low
  output reg         FL_BYTE_N,    // Width select: high word, low byte
  output reg         FL_WP_N       // write_protect_accel, low protects
);
  // Counts are worked out as integers, then cut to the counter width on purpose
  localparam integer T_RD_I  = `PFBD_CYC(`PFBD_T_ACC_NS) + `PFBD_SYNC_CYC;
  localparam integer T_WP_I  = `PFBD_CYC(`PFBD_T_WP_NS);
  localparam integer T_RST_I = `PFBD_CYC(`PFBD_T_RST_NS);
  // Read strobe also covers the data filter delay, else stale data would be captured
  localparam [`PFBD_CNT_W-1:0] T_ACC = T_RD_I[`PFBD_CNT_W-1:0];
  localparam [`PFBD_CNT_W-1:0] T_WP  = T_WP_I[`PFBD_CNT_W-1:0];
  localparam [`PFBD_CNT_W-1:0] T_RST = T_RST_I[`PFBD_CNT_W-1:0];
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_SETUP = 3'h1;
  localparam [2:0] S_RD = 3'h2;
  localparam [2:0] S_WR = 3'h3;
  localparam [2:0] S_HOLD = 3'h4;
  localparam [2:0] S_RST = 3'h5;

  reg  [4:0]  ctrl_r;
  reg  [26:0] addr_r;
  reg  [15:0] wdata_r;
  reg  [15:0] rdata_r;
  reg         done_r;
  reg  [2:0]  st_r;
  reg  [2:0]  st_nxt;
  reg  [`PFBD_CNT_W-1:0] cnt_r;
  reg  [`PFBD_CNT_W-1:0] cnt_nxt;
  wire [15:0] dq_sync;
  wire        is_write;
  wire        go_pulse;
  wire        rst_pulse;
  wire        byte_mode;

  // Data lines come from another domain and pass the three-stage filter
  pfbd_sync #(.W(16)) u_sync (
    .clk   (CLK_SYS),
    .rst_n (RSTN),
    .din   (FL_DQ_I),
    .dout  (dq_sync)
  );

  // Sector index of a word address: bits above the 64 Kword span
  function [`PFBD_SEC_W-1:0] sector_index;
    input [26:0] a;
    input        bm;
    begin
      // Word mode keeps the word address in bits 25:0, byte mode in bits 26:1
      if (bm)
        sector_index = a[`PFBD_SEC_LSB+`PFBD_SEC_W:`PFBD_SEC_LSB+1];
      else
        sector_index = a[`PFBD_SEC_LSB+`PFBD_SEC_W-1:`PFBD_SEC_LSB];
    end
  endfunction

  assign is_write  = PSEL & PENABLE & PWRITE;
  assign go_pulse  = is_write && PADDR == `PFBD_OFS_CTRL && PWDATA[`PFBD_CTRL_GO];
  assign rst_pulse = is_write && PADDR == `PFBD_OFS_CTRL && PWDATA[`PFBD_CTRL_RESET];
  assign byte_mode = ctrl_r[`PFBD_CTRL_BYTE];

  // Register file; commands are started only from idle, others ignored
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_r  <= `PFBD_CTRL_RST;
      addr_r  <= `PFBD_ADDR_RST;
      wdata_r <= `PFBD_DATA_RST;
    end else if (is_write) begin
      case (PADDR)
        `PFBD_OFS_CTRL: begin
          ctrl_r[`PFBD_CTRL_BYTE]  <= PWDATA[`PFBD_CTRL_BYTE];
          ctrl_r[`PFBD_CTRL_WPLOW] <= PWDATA[`PFBD_CTRL_WPLOW];
          ctrl_r[`PFBD_CTRL_WRITE] <= PWDATA[`PFBD_CTRL_WRITE];
        end
        `PFBD_OFS_ADDR:  addr_r  <= PWDATA[26:0];
        `PFBD_OFS_WDATA: wdata_r <= PWDATA[15:0];
        default: begin
        end
      endcase
    end
  end

  // APB answers in the access cycle itself: zero wait states
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      PRDATA  <= 32'h00000000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL & ~PENABLE;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h00000000;
      if (PSEL && !PENABLE) begin
        case (PADDR)
          `PFBD_OFS_CTRL:   PRDATA <= {27'h0000000, ctrl_r};
          `PFBD_OFS_ADDR:   PRDATA <= {5'h00, addr_r};
          `PFBD_OFS_WDATA:  PRDATA <= {16'h0000, wdata_r};
          `PFBD_OFS_RDATA:  PRDATA <= {16'h0000, rdata_r};
          `PFBD_OFS_STATUS: PRDATA <= {29'h00000000, byte_mode, done_r, st_r != S_IDLE};
          `PFBD_OFS_SECTOR: PRDATA <= {22'h000000, sector_index(addr_r, byte_mode)};
          default:          PSLVERR <= 1'b1;
        endcase
      end
    end
  end

  // Cycle sequencer: setup address with strobes high, then strobe, then hold
  always @* begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    if (cnt_r != {`PFBD_CNT_W{1'b0}})
      cnt_nxt = cnt_r - 1'b1;
    case (st_r)
      S_IDLE: begin
        if (rst_pulse) begin
          st_nxt  = S_RST;
          cnt_nxt = T_RST;
        end else if (go_pulse) begin
          st_nxt = S_SETUP;
        end
      end
      S_SETUP: begin
        st_nxt  = ctrl_r[`PFBD_CTRL_WRITE] ? S_WR : S_RD;
        cnt_nxt = ctrl_r[`PFBD_CTRL_WRITE] ? T_WP : T_ACC;
      end
      S_RD: if (cnt_r == {`PFBD_CNT_W{1'b0}}) st_nxt = S_HOLD;
      S_WR: if (cnt_r == {`PFBD_CNT_W{1'b0}}) st_nxt = S_HOLD;
      S_HOLD: st_nxt = S_IDLE;
      S_RST: if (cnt_r == {`PFBD_CNT_W{1'b0}}) st_nxt = S_IDLE;
      default: st_nxt = S_IDLE;
    endcase
  end

  // State, captured read data and done flag; a new start clears done
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      st_r    <= S_IDLE;
      cnt_r   <= {`PFBD_CNT_W{1'b0}};
      rdata_r <= `PFBD_DATA_RST;
      done_r  <= 1'b0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      if (st_r == S_RD && cnt_r == {`PFBD_CNT_W{1'b0}})
        rdata_r <= byte_mode ? {8'h00, dq_sync[7:0]} : dq_sync;
      if (st_nxt == S_IDLE && st_r != S_IDLE)
        done_r <= 1'b1;
      else if (go_pulse || rst_pulse)
        done_r <= 1'b0;
    end
  end

  // Pin drivers; every strobe is active low and idles high
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      FL_ADDR    <= 26'h0000000;
      FL_DQ_O    <= 16'h0000;
      FL_DQ_OE   <= 16'h0000;
      FL_CE_N    <= 1'b1;
      FL_OE_N    <= 1'b1;
      FL_WE_N    <= 1'b1;
      FL_RESET_N <= 1'b0;
      FL_BYTE_N  <= 1'b1;
      FL_WP_N    <= 1'b1;
    end else begin
      FL_RESET_N <= st_nxt != S_RST;
      FL_BYTE_N  <= ~byte_mode;
      FL_WP_N    <= ~ctrl_r[`PFBD_CTRL_WPLOW];
      // Byte mode: word address from bits above the byte-lane bit
      FL_ADDR    <= byte_mode ? addr_r[26:1] : addr_r[25:0];
      // Chip select falls with the address already stable, unless the start write also changes byte mode; device latches there
      FL_CE_N    <= !(st_nxt == S_RD || st_nxt == S_WR || st_nxt == S_HOLD);
      FL_OE_N    <= st_nxt != S_RD;
      FL_WE_N    <= st_nxt != S_WR;
      FL_DQ_O    <= byte_mode ? {addr_r[0], 7'h00, wdata_r[7:0]} : wdata_r;
      // Drive data during write; in byte mode the top line still carries A-1
      if (st_nxt == S_WR || st_nxt == S_HOLD && ctrl_r[`PFBD_CTRL_WRITE])
        FL_DQ_OE <= byte_mode ? 16'h80ff : 16'hffff;
      else if (byte_mode && st_nxt != S_IDLE && st_nxt != S_RST)
        FL_DQ_OE <= 16'h8000;
      else
        FL_DQ_OE <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// ===== pfbd_props.sv
// Checker on the flash controller pins and APB handshake
`timescale 1ns/1ns
`default_nettype none
module pfbd_props (
  input wire logic        CLK_SYS,    // Clock
  input wire logic        RSTN,       // Reset, active low
  input wire logic        PSEL,       // APB select
  input wire logic        PENABLE,    // APB access
  input wire logic        PREADY,     // APB ready
  input wire logic        PSLVERR,    // APB error
  input wire logic [25:0] FL_ADDR,    // Flash address
  input wire logic [15:0] FL_DQ_OE,   // Data enables
  input wire logic        FL_CE_N,    // Chip select
  input wire logic        FL_OE_N,    // Output enable
  input wire logic        FL_WE_N,    // Write strobe
  input wire logic        FL_RESET_N, // Flash reset
  input wire logic        FL_BYTE_N   // Width select
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  // Slave answers exactly one cycle after setup, for one cycle
  a_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("ready missing after setup");
  a_ready_one_cycle: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  a_err_with_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  // Read and write strobes never overlap and need chip select
  a_strobe_excl: assert property (!(!FL_OE_N && !FL_WE_N))
    else $error("both strobes low");
  a_strobe_ce: assert property (!FL_OE_N || !FL_WE_N |-> !FL_CE_N)
    else $error("strobe without select");
  // In byte mode the top line stays a host-driven address input during reads
  a_read_no_drive: assert property (!FL_OE_N |-> FL_DQ_OE[14:0] == 15'h0000 && FL_DQ_OE[15] == !FL_BYTE_N)
    else $error("host drives during read");
  a_reset_idle: assert property (!FL_RESET_N |-> FL_CE_N && FL_DQ_OE == 16'h0000)
    else $error("bus active during flash reset");
  a_byte_float: assert property (!FL_BYTE_N |-> FL_DQ_OE[14:8] == 7'h00)
    else $error("middle lines driven in byte mode");
  a_addr_held: assert property (!FL_CE_N && !$past(FL_CE_N) |-> $stable(FL_ADDR))
    else $error("address moved while selected");
  c_read: cover property (!FL_OE_N);
  c_write: cover property (!FL_WE_N);
  c_reset: cover property (!FL_RESET_N);
endmodule
bind pfbd_host pfbd_props u_props (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .PSEL(PSEL),
  .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .FL_ADDR(FL_ADDR),
  .FL_DQ_OE(FL_DQ_OE), .FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N),
  .FL_RESET_N(FL_RESET_N), .FL_BYTE_N(FL_BYTE_N));
`default_nettype wire

// ===== pfbd_regs.vh
// Register map, fields and timing constants of the parallel flash bus controller
`ifndef PFBD_REGS_VH
`define PFBD_REGS_VH
// Register word offsets on APB (byte addresses)
`define PFBD_OFS_CTRL    12'h000
`define PFBD_OFS_ADDR    12'h004
`define PFBD_OFS_WDATA   12'h008
`define PFBD_OFS_RDATA   12'h00c
`define PFBD_OFS_STATUS  12'h010
`define PFBD_OFS_SECTOR  12'h014
// Control register fields
`define PFBD_CTRL_GO     0
`define PFBD_CTRL_WRITE  1
`define PFBD_CTRL_RESET  2
`define PFBD_CTRL_BYTE   3
`define PFBD_CTRL_WPLOW  4
// Status register fields
`define PFBD_ST_BUSY     0
`define PFBD_ST_DONE     1
`define PFBD_ST_BYTE     2
// Address layout: word address is 26 bits, sector index from bit 16 up
`define PFBD_AW          26
`define PFBD_SEC_LSB     16
`define PFBD_SEC_W       10
`define PFBD_PAGE_W      3
// Timing counts in cycles of 40 ns (times in ns, counts rounded up)
`define PFBD_T_ACC_NS    120
`define PFBD_T_WP_NS     40
`define PFBD_T_RST_NS    520
`define PFBD_CLK_NS      40
`define PFBD_CYC(ns)     (((ns) + `PFBD_CLK_NS - 1) / `PFBD_CLK_NS)
`define PFBD_CNT_W       5
// Cycles from a settled data pin to a settled filter output: three stages and the vote
`define PFBD_SYNC_CYC    4
// Reset values
`define PFBD_CTRL_RST    5'h00
`define PFBD_ADDR_RST    27'h0000000
`define PFBD_DATA_RST    16'h0000
`endif

// ===== pfbd_sync.v
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module pfbd_sync #(
  parameter W = 16
) (
  input  wire         clk,     // System clock
  input  wire         rst_n,   // Async reset, active low
  input  wire [W-1:0] din,     // Raw pin levels
  output reg  [W-1:0] dout     // Filtered levels
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;

  // s1_r feeds only s2_r, so metastability never reaches the agreement check
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      dout <= (s2_r & s3_r) | (dout & (s2_r | s3_r));
    end
  end
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench: APB scenarios against the flash model
`timescale 1ns/1ns
`default_nettype none
`include "pfbd_regs.vh"
module tb_top;
  logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, err;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic        prdy, perr, ce_n, oe_n, we_n, frst_n, byte_n, wp_n;
  logic [25:0] fa;
  logic [15:0] dqi, dqo, dqe;
  int          n_errors = 0, num_checks = 0, cyc = 0;
  localparam logic [31:0] GO = 32'h1, WR = 32'h2, RS = 32'h4, BY = 32'h8, WP = 32'h10;
  localparam logic [26:0] A0 = 27'h0062468, AT = 27'h3ff0004;
  initial forever #20 clk = ~clk;
  pfbd_host u_dut (.CLK_SYS(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .FL_ADDR(fa),
    .FL_DQ_I(dqi), .FL_DQ_O(dqo), .FL_DQ_OE(dqe), .FL_CE_N(ce_n), .FL_OE_N(oe_n),
    .FL_WE_N(we_n), .FL_RESET_N(frst_n), .FL_BYTE_N(byte_n), .FL_WP_N(wp_n));
  pfbd_flash_model u_flash (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .rst_n(frst_n),
    .byte_n(byte_n), .wp_n(wp_n), .addr(fa), .dq_o(dqo), .dq_oe(dqe), .dq_i(dqi));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    rd = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // Flash cycle through the registers, then poll for done
  task automatic op(input logic [31:0] ctl, input logic [26:0] a, input logic [15:0] d);
    apb(1'b1, `PFBD_OFS_ADDR, {5'h00, a});
    apb(1'b1, `PFBD_OFS_WDATA, {16'h0000, d});
    apb(1'b1, `PFBD_OFS_CTRL, ctl);
    rd = 32'h0;
    while (rd[`PFBD_ST_DONE] !== 1'b1) apb(1'b0, `PFBD_OFS_STATUS, 32'h0);
    apb(1'b0, `PFBD_OFS_RDATA, 32'h0);
  endtask
  task automatic s_reset;
    chk({frst_n, wp_n, byte_n, ce_n}, 32'hf);
    apb(1'b0, `PFBD_OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic s_word;
    op(GO | WR, A0, 16'hbeef);
    op(GO, A0, 16'h0000);
    chk(rd, 32'hbeef);
    apb(1'b0, `PFBD_OFS_SECTOR, 32'h0);
    chk(rd, 32'h6);
    op(GO, 27'h0020016, 16'h0000);
    chk(rd, 32'h0f19);
    op(GO, A0 | 27'h7, 16'h0000);
    chk(rd, 32'h2b60);
  endtask
  task automatic s_protect;
    op(GO | WR | WP, AT, 16'h1111);
    op(GO | WP, AT, 16'h0000);
    chk(rd, 32'h0f0b);
    op(GO | WR, AT, 16'h2222);
    op(GO, AT, 16'h0000);
    chk(rd, 32'h2222);
    apb(1'b0, `PFBD_OFS_SECTOR, 32'h0);
    chk(rd, 32'h3ff);
  endtask
  task automatic s_byte;
    op(GO | BY, {A0[25:0], 1'b1}, 16'h0000);
    chk(rd, 32'hbe);
    op(GO | BY, {A0[25:0], 1'b0}, 16'h0000);
    chk({rd[15:0], 15'h0, byte_n}, 32'hef0000);
  endtask
  task automatic s_hw_reset;
    apb(1'b1, `PFBD_OFS_CTRL, RS);
    repeat (3) @(posedge clk);
    chk(frst_n, 1'b0);
    apb(1'b0, `PFBD_OFS_STATUS, 32'h0);
    chk(rd[`PFBD_ST_BUSY], 1'b1);
    // A start is refused while the reset pulse runs, so wait for it to end
    while (rd[`PFBD_ST_DONE] !== 1'b1) apb(1'b0, `PFBD_OFS_STATUS, 32'h0);
    chk(frst_n, 1'b1);
    op(GO, A0, 16'h0000);
    chk(rd, 32'hbeef);
    apb(1'b0, 12'h018, 32'h0);
    chk(err, 1'b1);
  endtask
  task automatic print_verdict;
    if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Hang guard: a few thousand cycles per scenario is ample
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    s_reset;
    s_word;
    s_protect;
    s_byte;
    s_hw_reset;
    print_verdict;
  end
endmodule
`default_nettype wire
